// file: inc/cow_pkg.sv
// Constants, types and field layout for the option word decoder
package cow_pkg;

    // Word geometry
    localparam int WORD_W = 13;

    // Word zero field positions
    localparam int W0_INSTR_PERIOD_BIT = 8;
    localparam int W0_WATCHDOG_DIS_BIT = 7;
    localparam int W0_CLOCK_SRC_MSB    = 6;
    localparam int W0_CLOCK_SRC_LSB    = 4;
    localparam int W0_POWER_LEVEL_BIT  = 3;
    localparam int W0_PROTECT_MSB      = 2;
    localparam int W0_PROTECT_LSB      = 0;

    // Word one field positions
    localparam int W1_SYSCLK_OUT_BIT   = 10;
    localparam int W1_PULSE_WIDTH_BIT  = 9;
    localparam int W1_NOISE_EN_BIT     = 8;
    localparam int W1_WD_PERIOD_BIT    = 7;
    localparam int W1_BRANCH_CYC_BIT   = 6;
    localparam int W1_TRIM_MSB         = 5;
    localparam int W1_TRIM_LSB         = 2;
    localparam int W1_RC_FREQ_MSB      = 1;
    localparam int W1_RC_FREQ_LSB      = 0;

    // Bits that always read as one
    localparam logic [12:0] W0_FORCED_ONES = 13'h1e00;
    localparam logic [12:0] W1_FORCED_ONES = 13'h1800;

    // Reset values, each the documented default setting
    localparam logic [12:0] W0_RESET = 13'h1ff7;
    localparam logic [12:0] W1_RESET = 13'h1fff;
    localparam logic [12:0] W2_RESET = 13'h0000;

    // Protection off only for all ones
    localparam logic [2:0] PROTECT_OFF_CODE = 3'h7;

    // Clock source encodings
    localparam logic [2:0] SRC_ERC_GPIO = 3'h0;
    localparam logic [2:0] SRC_ERC_OUT  = 3'h1;
    localparam logic [2:0] SRC_IRC_GPIO = 3'h2;
    localparam logic [2:0] SRC_IRC_OUT  = 3'h3;
    localparam logic [2:0] SRC_SLOW_XT  = 3'h6;
    localparam logic [2:0] SRC_FAST_XT  = 3'h7;

    // Noise pulse widths in oscillator periods
    localparam logic [5:0] NOISE_SHORT_FC = 6'h08;
    localparam logic [5:0] NOISE_LONG_FC  = 6'h20;

    // Watchdog nominal periods and clock rate
    localparam int CLK_MHZ       = 50;
    localparam int WD_LONG_US    = 18000;
    localparam int WD_SHORT_US   = 4500;
    localparam int WD_LONG_CYC   = WD_LONG_US * CLK_MHZ;
    localparam int WD_SHORT_CYC  = WD_SHORT_US * CLK_MHZ;

    // Oscillator mode, one-hot
    typedef enum logic [3:0] {
        OSC_EXT_RC  = 4'h1,
        OSC_INT_RC  = 4'h2,
        OSC_SLOW_XT = 4'h4,
        OSC_FAST_XT = 4'h8
    } cow_osc_e;

    // Internal RC frequency, one-hot
    typedef enum logic [3:0] {
        RC_455K = 4'h1,
        RC_1M   = 4'h2,
        RC_8M   = 4'h4,
        RC_4M   = 4'h8
    } cow_rcfreq_e;

    // Decoded static configuration
    typedef struct packed {
        logic        four_clk_instr;
        logic        watchdog_enable;
        cow_osc_e    osc_mode;
        logic        primary_pin_gpio;
        logic        secondary_pin_gpio;
        logic        secondary_pin_clock;
        logic        secondary_open_drain;
        logic        high_power;
        logic        code_protect;
        logic [5:0]  noise_min_width;
        logic        noise_filter_enable;
        logic        watchdog_long;
        logic        branch_two_cycles;
        logic [3:0]  rc_trim;
        cow_rcfreq_e rc_freq;
    } cow_cfg_s;

    // Raw option words after forcing
    typedef struct packed {
        logic [12:0] word0;
        logic [12:0] word1;
        logic [12:0] word2;
    } cow_words_s;

endpackage : cow_pkg

// file: src/cow_decoder.sv
// Option word decoder: latches the three option words and derives static settings
module cow_decoder
    import cow_pkg::*;
#(
    parameter int WD_LONG_CYCLES  = WD_LONG_CYC,   // Shorten for simulation
    parameter int WD_SHORT_CYCLES = WD_SHORT_CYC   // Shorten for simulation
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [12:0] otp_word0,
    input  wire logic [12:0] otp_word1,
    input  wire logic [12:0] otp_word2,
    input  wire logic        sleep_mode,
    output cow_cfg_s         cfg_q,
    output cow_words_s       words_q,
    output logic             cfg_valid_q,
    output logic             noise_filter_on_q,
    output logic [19:0]      wd_limit_q,
    output logic             branch_two_cycles_q,
    output logic [12:0]      customer_id_q
);

    // Load sequencer, one-hot
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } cow_state_e;

    cow_state_e state_q;     // Loader state
    cow_cfg_s   cfg_d;       // Decoded fields from the raw words
    cow_words_s words_d;     // Raw words with fixed bits forced

    // Decode clock source into mode
    function automatic cow_osc_e osc_decode(input logic [2:0] src);
        cow_osc_e m;
        m = OSC_FAST_XT;
        // Codes 100 and 101 are undefined; treated as crystal by bit 4
        if (src[2]) begin
            m = src[0] ? OSC_FAST_XT : OSC_SLOW_XT;
        end else if (src[1]) begin
            m = OSC_INT_RC;
        end else begin
            m = OSC_EXT_RC;
        end
        return m;
    endfunction : osc_decode

    // Decode RC frequency pair
    function automatic cow_rcfreq_e rc_decode(input logic [1:0] sel);
        cow_rcfreq_e f;
        f = RC_4M;
        case (sel)
            2'h3:    f = RC_4M;
            2'h2:    f = RC_8M;
            2'h1:    f = RC_1M;
            default: f = RC_455K;
        endcase
        return f;
    endfunction : rc_decode

    // Force fixed bits so readback always shows them high
    always_comb begin
        words_d.word0 = otp_word0 | W0_FORCED_ONES;
        words_d.word1 = otp_word1 | W1_FORCED_ONES;
        words_d.word2 = otp_word2;
    end

    // Field decode; type bit is never consulted
    always_comb begin
        logic [2:0] src;
        logic       rc_mode;
        logic       xt_mode;
        src     = words_d.word0[W0_CLOCK_SRC_MSB:W0_CLOCK_SRC_LSB];
        xt_mode = 1'b0;
        rc_mode = 1'b0;
        cfg_d   = '0;
        cfg_d.four_clk_instr  = words_d.word0[W0_INSTR_PERIOD_BIT];
        cfg_d.watchdog_enable = ~words_d.word0[W0_WATCHDOG_DIS_BIT];
        cfg_d.osc_mode        = osc_decode(src);
        xt_mode = (cfg_d.osc_mode == OSC_FAST_XT) || (cfg_d.osc_mode == OSC_SLOW_XT);
        rc_mode = ~xt_mode;
        // Crystal owns both pins; only internal RC frees primary, either RC mode frees secondary when bit 4 is low
        cfg_d.primary_pin_gpio   = (cfg_d.osc_mode == OSC_INT_RC);
        cfg_d.secondary_pin_gpio = rc_mode & ~src[0];
        // Secondary pin in RC with clock role: drive clock or float
        cfg_d.secondary_pin_clock = rc_mode & src[0]
                                    & words_d.word1[W1_SYSCLK_OUT_BIT];
        cfg_d.secondary_open_drain = rc_mode & src[0]
                                     & ~words_d.word1[W1_SYSCLK_OUT_BIT];
        cfg_d.high_power   = words_d.word0[W0_POWER_LEVEL_BIT];
        cfg_d.code_protect = (words_d.word0[W0_PROTECT_MSB:W0_PROTECT_LSB]
                              != PROTECT_OFF_CODE);
        cfg_d.noise_min_width = words_d.word1[W1_PULSE_WIDTH_BIT] ?
                                NOISE_LONG_FC : NOISE_SHORT_FC;
        // Slow crystal forces the filter off regardless of the bit
        cfg_d.noise_filter_enable = words_d.word1[W1_NOISE_EN_BIT]
                                    & (cfg_d.osc_mode != OSC_SLOW_XT);
        cfg_d.watchdog_long     = words_d.word1[W1_WD_PERIOD_BIT];
        cfg_d.branch_two_cycles = words_d.word1[W1_BRANCH_CYC_BIT];
        // Trim passed through; programmer is expected to leave it all ones
        cfg_d.rc_trim = words_d.word1[W1_TRIM_MSB:W1_TRIM_LSB];
        cfg_d.rc_freq = rc_decode(words_d.word1[W1_RC_FREQ_MSB:W1_RC_FREQ_LSB]);
    end

    // Default settings shown until the first load completes
    function automatic cow_cfg_s cfg_default();
        cow_cfg_s c;
        c = '0;
        c.four_clk_instr      = 1'b1;
        c.watchdog_enable     = 1'b0;
        c.osc_mode            = OSC_FAST_XT;
        // Power level follows the reset word so readback and decode agree
        c.high_power          = W0_RESET[W0_POWER_LEVEL_BIT];
        c.code_protect        = 1'b0;
        c.noise_min_width     = NOISE_LONG_FC;
        c.noise_filter_enable = 1'b1;
        c.watchdog_long       = 1'b1;
        c.branch_two_cycles   = 1'b1;
        c.rc_trim             = 4'hf;
        c.rc_freq             = RC_4M;
        return c;
    endfunction : cfg_default

    // Loader: one capture after reset release, then frozen until the next reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_LOAD;
        end else begin
            case (state_q)
                ST_LOAD: state_q <= ST_RUN;
                ST_RUN:  state_q <= ST_RUN;   // No way back short of reset
                default: state_q <= ST_LOAD;
            endcase
        end
    end

    // Capture decoded settings and raw words in the load cycle only
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q         <= cfg_default();
            words_q.word0 <= W0_RESET;
            words_q.word1 <= W1_RESET;
            words_q.word2 <= W2_RESET;
            cfg_valid_q   <= 1'b0;
        end else if (state_q == ST_LOAD) begin
            cfg_q       <= cfg_d;
            words_q     <= words_d;
            cfg_valid_q <= 1'b1;
        end
    end

    // Extra copies driven from the same load for convenience
    always_ff @(posedge clk) begin
        if (rst) begin
            branch_two_cycles_q <= 1'b1;
            customer_id_q       <= W2_RESET;
        end else if (state_q == ST_LOAD) begin
            branch_two_cycles_q <= cfg_d.branch_two_cycles;
            customer_id_q       <= words_d.word2;
        end
    end

    // Watchdog limit in clock cycles; recomputed each cycle from frozen bit
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_limit_q <= 20'(WD_LONG_CYCLES);
        end else begin
            wd_limit_q <= cfg_q.watchdog_long ? 20'(WD_LONG_CYCLES)
                                              : 20'(WD_SHORT_CYCLES);
        end
    end

    // Live noise filter gate; sleep is the only runtime input that matters
    always_ff @(posedge clk) begin
        if (rst) begin
            noise_filter_on_q <= 1'b0;
        end else begin
            noise_filter_on_q <= cfg_q.noise_filter_enable & ~sleep_mode;
        end
    end

    // Checks, all on clk with reset disabling them
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Helper: cycles since the load completed, saturating
    logic [3:0] run_cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            run_cnt_q <= 4'h0;
        end else if (cfg_valid_q && run_cnt_q != 4'hf) begin
            run_cnt_q <= run_cnt_q + 4'h1;
        end
    end

    property p_forced_ones;
        cfg_valid_q |-> ((words_q.word0 & W0_FORCED_ONES) == W0_FORCED_ONES)
                    && ((words_q.word1 & W1_FORCED_ONES) == W1_FORCED_ONES);
    endproperty
    a_forced_ones: assert property (p_forced_ones)
        else $error("fixed option bits not high");

    property p_frozen;
        cfg_valid_q |=> $stable(cfg_q) && $stable(words_q) && cfg_valid_q;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("option settings changed after load");

    property p_load_once;
        $rose(cfg_valid_q) |-> $past(state_q) == ST_LOAD
                               && words_q.word2 == $past(otp_word2);
    endproperty
    a_load_once: assert property (p_load_once)
        else $error("load did not capture the words");

    property p_watchdog;
        cfg_valid_q |-> cfg_q.watchdog_enable == ~words_q.word0[W0_WATCHDOG_DIS_BIT];
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog enable polarity wrong");

    property p_protect;
        cfg_valid_q |-> cfg_q.code_protect
                        == (words_q.word0[W0_PROTECT_MSB:W0_PROTECT_LSB] != PROTECT_OFF_CODE);
    endproperty
    a_protect: assert property (p_protect)
        else $error("code protection decode wrong");

    property p_crystal_pins;
        (cfg_q.osc_mode == OSC_FAST_XT || cfg_q.osc_mode == OSC_SLOW_XT)
            |-> !cfg_q.primary_pin_gpio && !cfg_q.secondary_pin_gpio
                && !cfg_q.secondary_pin_clock && !cfg_q.secondary_open_drain;
    endproperty
    a_crystal_pins: assert property (p_crystal_pins)
        else $error("crystal pin used as general I/O");

    property p_sleep_filter;
        sleep_mode |=> !noise_filter_on_q;
    endproperty
    a_sleep_filter: assert property (p_sleep_filter)
        else $error("noise filter on during sleep");

    property p_slow_xt_filter;
        cfg_q.osc_mode == OSC_SLOW_XT |-> ##1 !noise_filter_on_q [*2];
    endproperty
    a_slow_xt_filter: assert property (p_slow_xt_filter)
        else $error("noise filter on in slow crystal mode");

    property p_wd_limit;
        run_cnt_q >= 4'h2 |-> wd_limit_q == (cfg_q.watchdog_long ? 20'(WD_LONG_CYCLES)
                                                                : 20'(WD_SHORT_CYCLES));
    endproperty
    a_wd_limit: assert property (p_wd_limit)
        else $error("watchdog limit does not match period bit");

    property p_pulse_width;
        cfg_valid_q |-> cfg_q.noise_min_width == (words_q.word1[W1_PULSE_WIDTH_BIT]
                                                  ? NOISE_LONG_FC : NOISE_SHORT_FC);
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("noise pulse width wrong");

    property p_rc_freq;
        cfg_valid_q && words_q.word1[W1_RC_FREQ_MSB:W1_RC_FREQ_LSB] == 2'h3
            |-> cfg_q.rc_freq == RC_4M;
    endproperty
    a_rc_freq: assert property (p_rc_freq)
        else $error("RC frequency decode wrong");

    property p_branch;
        cfg_valid_q |-> branch_two_cycles_q == words_q.word1[W1_BRANCH_CYC_BIT]
                        && cfg_q.four_clk_instr == words_q.word0[W0_INSTR_PERIOD_BIT];
    endproperty
    a_branch: assert property (p_branch)
        else $error("cycle selection decode wrong");

    // Pin roles, power level, customer code and RC frequency against the captured words, filter gate against settings and sleep
    property p_int_rc_pins;
        cfg_valid_q && words_q.word0[W0_CLOCK_SRC_MSB -: 2] == 2'h1
            |-> cfg_q.primary_pin_gpio && cfg_q.osc_mode == OSC_INT_RC;
    endproperty
    a_int_rc_pins: assert property (p_int_rc_pins)
        else $error("primary pin not freed in internal RC mode");

    property p_sysclk_pin;
        cfg_valid_q && (cfg_q.osc_mode == OSC_EXT_RC || cfg_q.osc_mode == OSC_INT_RC)
            && words_q.word0[W0_CLOCK_SRC_LSB]
            |-> cfg_q.secondary_pin_clock == words_q.word1[W1_SYSCLK_OUT_BIT]
                && cfg_q.secondary_open_drain == !words_q.word1[W1_SYSCLK_OUT_BIT];
    endproperty
    a_sysclk_pin: assert property (p_sysclk_pin)
        else $error("secondary pin clock role wrong");

    property p_secondary_gpio;
        cfg_valid_q && !words_q.word0[W0_CLOCK_SRC_MSB]
            |-> cfg_q.secondary_pin_gpio == !words_q.word0[W0_CLOCK_SRC_LSB];
    endproperty
    a_secondary_gpio: assert property (p_secondary_gpio)
        else $error("secondary pin I/O role wrong");

    property p_power;
        cfg_valid_q |-> cfg_q.high_power == words_q.word0[W0_POWER_LEVEL_BIT];
    endproperty
    a_power: assert property (p_power)
        else $error("power level decode wrong");

    property p_customer_id;
        cfg_valid_q |-> customer_id_q == words_q.word2;
    endproperty
    a_customer_id: assert property (p_customer_id)
        else $error("customer code copy wrong");

    property p_rc_freq_all;
        cfg_valid_q |-> cfg_q.rc_freq
            == (words_q.word1[W1_RC_FREQ_MSB]
                ? (words_q.word1[W1_RC_FREQ_LSB] ? RC_4M : RC_8M)
                : (words_q.word1[W1_RC_FREQ_LSB] ? RC_1M : RC_455K));
    endproperty
    a_rc_freq_all: assert property (p_rc_freq_all)
        else $error("RC frequency code not decoded");

    property p_filter_follow;
        cfg_valid_q |-> noise_filter_on_q
                        == $past(cfg_q.noise_filter_enable && !sleep_mode);
    endproperty
    a_filter_follow: assert property (p_filter_follow)
        else $error("noise filter gate does not follow settings");

endmodule : cow_decoder

// file: dv/cow_decoder_tb.sv
// Self-checking testbench for the option word decoder
module cow_decoder_tb
    import cow_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LONG_C  = 40;  // Shortened long watchdog limit
    localparam int SHORT_C = 10;  // Shortened short watchdog limit

    logic        clk;                 // 50 MHz clock
    logic        rst;                 // Synchronous reset
    logic [12:0] otp_word0;           // Raw word zero
    logic [12:0] otp_word1;           // Raw word one
    logic [12:0] otp_word2;           // Raw customer word
    logic        sleep_mode;          // Core sleep level
    cow_cfg_s    cfg_q;               // Decoded settings
    cow_words_s  words_q;             // Captured words
    logic        cfg_valid_q;         // Load done
    logic        noise_filter_on_q;   // Live filter state
    logic [19:0] wd_limit_q;          // Watchdog limit
    logic        branch_two_cycles_q; // Branch cycle choice
    logic [12:0] customer_id_q;       // Customer code
    logic [12:0] w0, w1, w2;          // Words of the current case
    int          n_errors;            // Mismatch count
    int          checks;              // Comparison count

    cow_decoder #(
        .WD_LONG_CYCLES  (LONG_C),
        .WD_SHORT_CYCLES (SHORT_C)
    ) dut_u (
        .clk                 (clk),
        .rst                 (rst),
        .otp_word0           (otp_word0),
        .otp_word1           (otp_word1),
        .otp_word2           (otp_word2),
        .sleep_mode          (sleep_mode),
        .cfg_q               (cfg_q),
        .words_q             (words_q),
        .cfg_valid_q         (cfg_valid_q),
        .noise_filter_on_q   (noise_filter_on_q),
        .wd_limit_q          (wd_limit_q),
        .branch_two_cycles_q (branch_two_cycles_q),
        .customer_id_q       (customer_id_q)
    );

    // Free running clock
    initial clk = 1'b0;
    always #10 clk = ~clk;

    // Verdict and end of run, shared with the watchdog
    task automatic finish_test();
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Flag comparison
    task automatic chk_b(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_b

    // Vector comparison
    task automatic chk_v(input logic [19:0] got, input logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_v

    // Source code to mode; undefined 100/101 follow bit 4
    function automatic cow_osc_e osc_of(input logic [2:0] s);
        if (s[2]) begin
            return s[0] ? OSC_FAST_XT : OSC_SLOW_XT;
        end
        return s[1] ? OSC_INT_RC : OSC_EXT_RC;
    endfunction : osc_of

    // Frequency code to one-hot choice
    function automatic cow_rcfreq_e rc_of(input logic [1:0] f);
        case (f)
            2'h3:    return RC_4M;
            2'h2:    return RC_8M;
            2'h1:    return RC_1M;
            default: return RC_455K;
        endcase
    endfunction : rc_of

    // Reset, release, and let three edges pass: the single load edge, then the derived outputs
    task automatic load(input logic [12:0] a, input logic [12:0] b, input logic [12:0] c);
        rst = 1'b1;
        otp_word0 = a;
        otp_word1 = b;
        otp_word2 = c;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
    endtask : load

    // Every output against the settings worked out from the words
    task automatic check_all(input logic [12:0] a, input logic [12:0] b, input logic [12:0] c);
        cow_osc_e m;
        logic     rc;
        logic     nfe;
        m = osc_of(a[6:4]);
        rc = (m == OSC_EXT_RC) || (m == OSC_INT_RC);
        nfe = b[8] && (m != OSC_SLOW_XT);
        chk_b(cfg_valid_q, 1'b1);
        chk_v(20'(words_q.word0), 20'(a | 13'h1e00));
        chk_v(20'(words_q.word1), 20'(b | 13'h1800));
        chk_v(20'(words_q.word2), 20'(c));
        chk_v(20'(customer_id_q), 20'(c));
        chk_b(cfg_q.four_clk_instr, a[8]);
        chk_b(cfg_q.watchdog_enable, ~a[7]);
        chk_v(20'(cfg_q.osc_mode), 20'(m));
        chk_b(cfg_q.primary_pin_gpio, m == OSC_INT_RC);
        chk_b(cfg_q.secondary_pin_gpio, rc && !a[4]);
        chk_b(cfg_q.secondary_pin_clock, rc && a[4] && b[10]);
        chk_b(cfg_q.secondary_open_drain, rc && a[4] && !b[10]);
        chk_b(cfg_q.high_power, a[3]);
        chk_b(cfg_q.code_protect, a[2:0] != 3'h7);
        chk_v(20'(cfg_q.noise_min_width), b[9] ? 20'h00020 : 20'h00008);
        chk_b(cfg_q.noise_filter_enable, nfe);
        chk_b(cfg_q.watchdog_long, b[7]);
        chk_b(cfg_q.branch_two_cycles, b[6]);
        chk_b(branch_two_cycles_q, b[6]);
        chk_v(20'(cfg_q.rc_trim), 20'(b[5:2]));
        chk_v(20'(cfg_q.rc_freq), 20'(rc_of(b[1:0])));
        chk_v(wd_limit_q, b[7] ? 20'(LONG_C) : 20'(SHORT_C));
        chk_b(noise_filter_on_q, nfe);
    endtask : check_all

    // Main sequence
    initial begin
        n_errors = 0;
        checks = 0;
        rst = 1'b1;
        sleep_mode = 1'b0;
        otp_word0 = 13'h0000;
        otp_word1 = 13'h0000;
        otp_word2 = 13'h0000;
        repeat (6) @(negedge clk);
        // Defaults while held in reset, zero words ignored
        chk_b(cfg_valid_q, 1'b0);
        chk_v(20'(words_q.word0), 20'h01ff7);
        chk_v(20'(words_q.word1), 20'h01fff);
        chk_v(20'(customer_id_q), 20'h00000);
        chk_v(20'(cfg_q.osc_mode), 20'(OSC_FAST_XT));
        chk_v(20'(cfg_q.rc_freq), 20'(RC_4M));
        chk_b(cfg_q.four_clk_instr, 1'b1);
        chk_b(cfg_q.watchdog_enable, 1'b0);
        chk_b(cfg_q.code_protect, 1'b0);
        chk_b(cfg_q.high_power, W0_RESET[W0_POWER_LEVEL_BIT]);
        chk_b(branch_two_cycles_q, 1'b1);
        chk_v(wd_limit_q, 20'(LONG_C));
        chk_b(noise_filter_on_q, 1'b0);
        // Every source code, every frequency code, mixed fields
        for (int i = 0; i < 8; i++) begin
            w0 = {i[0] ? 4'hf : 4'h0, i[0], i[1], i[2:0], i[2], i[2:0]};
            w1 = {i[0] ? 2'h3 : 2'h0, i[1], i[0], ~i[2] | i[0], i[1], i[2], 4'hf, i[1:0]};
            w2 = 13'h0a5a ^ 13'(i);
            load(w0, w1, w2);
            check_all(w0, w1, w2);
            // Sleep forces the filter off, one cycle lag
            sleep_mode = 1'b1;
            @(negedge clk);
            chk_b(noise_filter_on_q, 1'b0);
            sleep_mode = 1'b0;
            @(negedge clk);
            chk_b(noise_filter_on_q, w1[8] && (osc_of(w0[6:4]) != OSC_SLOW_XT));
            // Later word changes must not reach the settings
            otp_word0 = ~w0;
            otp_word1 = ~w1;
            otp_word2 = ~w2;
            repeat (4) @(negedge clk);
            check_all(w0, w1, w2);
        end
        finish_test();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #100us;
        n_errors++;
        $display("Error at %0t: run did not complete", $time);
        finish_test();
    end

endmodule : cow_decoder_tb
